/* File: hdl/asrb_pkg.sv */
// constants, register map and state types of the sensor register bank
package asrb_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MEMCHK_TIME_NS = 85000;

  localparam logic [5:0] ADDR_REVISION = 6'h00;
  localparam logic [5:0] ADDR_CONTROL = 6'h01;
  localparam logic [5:0] ADDR_STATUS = 6'h02;
  localparam logic [5:0] ADDR_RESET_KEY = 6'h03;
  localparam logic [5:0] ADDR_TEMP_LOW = 6'h12;
  localparam logic [5:0] ADDR_TEMP_HIGH = 6'h13;
  localparam logic [5:0] ADDR_ALARM = 6'h16;
  localparam logic [5:0] ADDR_PART = 6'h27;

  localparam int unsigned CTRL_POR = 6;
  localparam int unsigned CTRL_PDOWN = 5;
  localparam int unsigned CTRL_SLEEP = 4;
  localparam int unsigned CTRL_SELF = 3;
  localparam int unsigned CTRL_MEM = 2;
  localparam int unsigned CTRL_OPT = 1;
  localparam logic [7:0] CTRL_RST_MULTI = 8'h44;
  localparam logic [7:0] CTRL_RST_SINGLE = 8'h4c;

  localparam int unsigned ALARM_OVER = 7;
  localparam int unsigned ALARM_GRAV = 6;
  localparam int unsigned ALARM_CONT = 5;

  localparam logic [7:0] KEY_FIRST = 8'h0c;
  localparam logic [7:0] KEY_SECOND = 8'h05;
  localparam logic [7:0] KEY_THIRD = 8'h0f;

  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CAP_COUNT = 5'h06;
  localparam logic [4:0] COUNT_MAX = 5'h1f;
  localparam logic [15:0] TEMP_RST = 16'h0000;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT1 = 3'b010,
    KEY_GOT2 = 3'b100
  } asrb_key_t;

  typedef struct packed {
    logic sck;
    logic csb;
    logic mosi;
  } asrb_spi_in_t;

  typedef struct packed {
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic csb_m;
    logic csb_s;
    logic csb_d;
    logic mosi_m;
    logic mosi_s;
    logic in_frame;
    logic frame_blocked;
    logic [4:0] bitcnt;
    logic [4:0] fallcnt;
    logic [15:0] rx;
    logic [15:0] resp;
    logic miso;
    logic miso_oe_n;
    logic [7:0] ctrl;
    logic framing_fault;
    logic checksum_fault;
    logic [7:0] alarm;
    logic [7:0] temp_lat;
    logic [7:0] key_reg;
    asrb_key_t key_stage;
    logic [7:0] part;
    logic part_loaded;
    logic [13:0] mem_cnt;
    logic soft_reset;
  } asrb_state_t;

endpackage

/* File: hdl/asrb_top.sv */
// register bank with spi slave port of the accelerometer interface chip
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - reading temperature high byte latches low byte for the next read
// - single-axis: temperature is two's complement in bits 13:0
// - multi-axis: temperature is unsigned in bits 13:1
// - status bit 2 mirrors analog test mode, read-only, resets to 0
// - status bit 1 is checksum fault; multi-axis also raises frame self-test bit
// - status bit 0 is frame error, held until next good frame, also in frame
// - alarm bit 7 flags saturation, mirrored in frame, needs acknowledge
// - alarm bit 6 flags gravity self-test failure and raises frame self-test bit
// - alarm bit 5 flags continuous self-test failure and raises frame self-test bit
// - alarm flags stay set until alarm register is read
// - control bit 6 set only by power-up, cleared by writing 0, frame bit 13
// - control bit 5 set puts the chip into power-down
// - sleep refused when power-down is set or being set
// - multi-axis: continuous self-test refused under power-down, sleep or memory test
// - single-axis: deflection self-test, self clearing, refused under power-down, runs at start
// - memory test self clears, blocks serial access 85us, runs at start
// - multi-axis: gravity self-test refused under power-down, sleep or memory test
// - single-axis: control bit 1 picks deflection direction
// - reset key values 0x0c, 0x05, 0x0f in order reset the component
// - revision register is read-only fixed code
// - part code loads from nvm, writable, top bit shows multi-axis
// - response header carries frame error, power-up, self-test, saturation bits
// - writes commit only at chip select rise and only for valid frames
// - reserved addresses read as zero
module asrb_top #(
  parameter bit MULTI_AXIS = 1'b1,
  parameter int unsigned MEMCHK_TIME_NS = asrb_pkg::MEMCHK_TIME_NS,
  parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire asrb_pkg::asrb_spi_in_t spi_in,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic [13:0] temp_raw,
  input wire logic analog_check_active,
  input wire logic checksum_bad,
  input wire logic over_range_event,
  input wire logic gravity_fail_event,
  input wire logic continuous_fail_event,
  input wire logic selfcheck_done,
  input wire logic [7:0] nvm_part_code,
  output logic power_up_flag,
  output logic power_down_request,
  output logic sleep_mode,
  output logic selfcheck_trigger,
  output logic memory_check_go,
  output logic selfcheck_option,
  output logic soft_reset
);

  // least time, rounded up to whole cycles
  localparam int unsigned MEM_CYCLES = (MEMCHK_TIME_NS + asrb_pkg::CLK_PERIOD_NS - 1) / asrb_pkg::CLK_PERIOD_NS;
  localparam logic [13:0] MEM_LAST = 14'(MEM_CYCLES - 1);
  localparam logic [7:0] CTRL_RST = MULTI_AXIS ? asrb_pkg::CTRL_RST_MULTI : asrb_pkg::CTRL_RST_SINGLE;
  localparam asrb_pkg::asrb_state_t RST_STATE = '{
    csb_m: 1'b1, csb_s: 1'b1, csb_d: 1'b1, miso_oe_n: 1'b1,
    ctrl: CTRL_RST, key_stage: asrb_pkg::KEY_IDLE, default: '0};

  asrb_pkg::asrb_state_t st;
  asrb_pkg::asrb_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection and read path
  logic sck_rise;
  logic sck_fall;
  logic csb_dn;
  logic csb_up;
  logic cap;
  logic [5:0] cap_addr;
  logic cap_rw;
  logic [15:0] temp_word;
  logic [7:0] rd_data;
  logic st_bit;
  logic sat_bit;
  logic frame_ok;

  assign sck_rise = st.sck_s & ~st.sck_d;
  assign sck_fall = ~st.sck_s & st.sck_d;
  assign csb_dn = ~st.csb_s & st.csb_d;
  assign csb_up = st.csb_s & ~st.csb_d;
  assign cap = clk_en & sck_rise & st.in_frame & ~st.csb_s & ~st.frame_blocked & (st.bitcnt == asrb_pkg::CAP_COUNT);
  assign cap_addr = st.rx[5:0];
  assign cap_rw = st.mosi_s;
  // multi-axis unsigned 13:1, single-axis signed 13:0 with sign copied up
  assign temp_word = MULTI_AXIS ? {2'b00, temp_raw[12:0], 1'b0} : {{2{temp_raw[13]}}, temp_raw};
  assign st_bit = MULTI_AXIS & (st.checksum_fault | st.alarm[asrb_pkg::ALARM_GRAV] | st.alarm[asrb_pkg::ALARM_CONT]);
  assign sat_bit = MULTI_AXIS & st.alarm[asrb_pkg::ALARM_OVER];
  assign frame_ok = (st.bitcnt == asrb_pkg::FRAME_BITS) & (^st.rx[15:8]);

  always_comb begin
    case (cap_addr)
      asrb_pkg::ADDR_REVISION: rd_data = REVISION_CODE;
      asrb_pkg::ADDR_CONTROL: rd_data = st.ctrl;
      asrb_pkg::ADDR_STATUS: rd_data = {5'h00, analog_check_active, st.checksum_fault, st.framing_fault};
      asrb_pkg::ADDR_RESET_KEY: rd_data = st.key_reg;
      asrb_pkg::ADDR_TEMP_LOW: rd_data = st.temp_lat;
      asrb_pkg::ADDR_TEMP_HIGH: rd_data = temp_word[15:8];
      asrb_pkg::ADDR_ALARM: rd_data = MULTI_AXIS ? st.alarm : 8'h00;
      asrb_pkg::ADDR_PART: rd_data = st.part;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] w;
    logic pd_blk;
    logic sl_blk;
    logic self_blk;
    logic do_soft;
    w = st.rx[7:0];
    pd_blk = st.ctrl[asrb_pkg::CTRL_PDOWN] | w[asrb_pkg::CTRL_PDOWN];
    sl_blk = pd_blk | st.ctrl[asrb_pkg::CTRL_SLEEP] | w[asrb_pkg::CTRL_SLEEP];
    self_blk = MULTI_AXIS ? (sl_blk | st.ctrl[asrb_pkg::CTRL_MEM] | w[asrb_pkg::CTRL_MEM]) : pd_blk;
    do_soft = 1'b0;
    next_st = st;
    next_st.soft_reset = 1'b0;
    next_st.sck_m = spi_in.sck;
    next_st.sck_s = st.sck_m;
    next_st.sck_d = st.sck_s;
    next_st.csb_m = spi_in.csb;
    next_st.csb_s = st.csb_m;
    next_st.csb_d = st.csb_s;
    next_st.mosi_m = spi_in.mosi;
    next_st.mosi_s = st.mosi_m;

    // part code is taken once after reset; the msb names the variant
    if (!st.part_loaded) begin
      next_st.part = {MULTI_AXIS, nvm_part_code[6:0]};
      next_st.part_loaded = 1'b1;
    end

    // memory test: runs at start and on request, result lands in checksum flag
    if (st.ctrl[asrb_pkg::CTRL_MEM]) begin
      if (st.mem_cnt == MEM_LAST) begin
        next_st.ctrl[asrb_pkg::CTRL_MEM] = 1'b0;
        next_st.mem_cnt = 14'h0000;
        next_st.checksum_fault = checksum_bad;
      end else begin
        next_st.mem_cnt = st.mem_cnt + 14'h0001;
      end
    end

    if (selfcheck_done) begin
      if (MULTI_AXIS) begin
        next_st.ctrl[asrb_pkg::CTRL_OPT] = 1'b0;
      end else begin
        next_st.ctrl[asrb_pkg::CTRL_SELF] = 1'b0;
      end
    end

    // frame start: access refused while the memory test runs
    if (csb_dn) begin
      next_st.in_frame = 1'b1;
      next_st.frame_blocked = st.ctrl[asrb_pkg::CTRL_MEM];
      next_st.bitcnt = 5'h00;
      next_st.fallcnt = 5'h00;
      next_st.resp = {1'b0, st.framing_fault, st.ctrl[asrb_pkg::CTRL_POR], st_bit, sat_bit,
                      1'b0, 1'b1, 1'b0, 8'h00};
    end

    if (st.in_frame && !st.csb_s) begin
      if (sck_rise) begin
        next_st.rx = {st.rx[14:0], st.mosi_s};
        if (st.bitcnt != asrb_pkg::COUNT_MAX) begin
          next_st.bitcnt = st.bitcnt + 5'h01;
        end
      end
      if (sck_fall && st.fallcnt != asrb_pkg::COUNT_MAX) begin
        next_st.fallcnt = st.fallcnt + 5'h01;
      end
    end

    // address known after seven bits: data and its parity go out next
    if (cap) begin
      next_st.resp[8:0] = {~^rd_data, rd_data};
      if (!cap_rw && cap_addr == asrb_pkg::ADDR_TEMP_HIGH) begin
        next_st.temp_lat = temp_word[7:0];
      end
      if (!cap_rw && cap_addr == asrb_pkg::ADDR_ALARM) begin
        next_st.alarm = 8'h00;
      end
    end

    // frame end: commit writes of good frames only
    if (csb_up && st.in_frame) begin
      next_st.in_frame = 1'b0;
      if (!st.frame_blocked) begin
        next_st.framing_fault = ~frame_ok;
        if (frame_ok && st.rx[9]) begin
          case (st.rx[15:10])
            asrb_pkg::ADDR_CONTROL: begin
              next_st.ctrl[7] = 1'b0;
              next_st.ctrl[asrb_pkg::CTRL_POR] = st.ctrl[asrb_pkg::CTRL_POR] & w[asrb_pkg::CTRL_POR];
              next_st.ctrl[asrb_pkg::CTRL_PDOWN] = w[asrb_pkg::CTRL_PDOWN];
              next_st.ctrl[asrb_pkg::CTRL_SLEEP] = w[asrb_pkg::CTRL_SLEEP] & (st.ctrl[asrb_pkg::CTRL_SLEEP] | ~pd_blk);
              next_st.ctrl[asrb_pkg::CTRL_SELF] = w[asrb_pkg::CTRL_SELF] & (st.ctrl[asrb_pkg::CTRL_SELF] | ~self_blk);
              next_st.ctrl[asrb_pkg::CTRL_MEM] = w[asrb_pkg::CTRL_MEM] & ~sl_blk;
              next_st.ctrl[asrb_pkg::CTRL_OPT] = MULTI_AXIS ?
                (w[asrb_pkg::CTRL_OPT] & (st.ctrl[asrb_pkg::CTRL_OPT] | ~self_blk)) : w[asrb_pkg::CTRL_OPT];
              next_st.ctrl[0] = 1'b0;
              next_st.mem_cnt = 14'h0000;
            end
            asrb_pkg::ADDR_RESET_KEY: begin
              next_st.key_reg = w;
              // a wrong value restarts matching, a first value restarts it at once
              case (st.key_stage)
                asrb_pkg::KEY_IDLE: next_st.key_stage = (w == asrb_pkg::KEY_FIRST) ? asrb_pkg::KEY_GOT1 : asrb_pkg::KEY_IDLE;
                asrb_pkg::KEY_GOT1: next_st.key_stage = (w == asrb_pkg::KEY_SECOND) ? asrb_pkg::KEY_GOT2 :
                  ((w == asrb_pkg::KEY_FIRST) ? asrb_pkg::KEY_GOT1 : asrb_pkg::KEY_IDLE);
                asrb_pkg::KEY_GOT2: begin
                  if (w == asrb_pkg::KEY_THIRD) begin
                    do_soft = 1'b1;
                  end else begin
                    next_st.key_stage = (w == asrb_pkg::KEY_FIRST) ? asrb_pkg::KEY_GOT1 : asrb_pkg::KEY_IDLE;
                  end
                end
                default: next_st.key_stage = asrb_pkg::KEY_IDLE;
              endcase
            end
            asrb_pkg::ADDR_PART: next_st.part = w;
            default: next_st.part = next_st.part;
          endcase
        end
      end
    end

    // events win over the acknowledge in the same cycle
    if (MULTI_AXIS) begin
      next_st.alarm[asrb_pkg::ALARM_OVER] = next_st.alarm[asrb_pkg::ALARM_OVER] | over_range_event;
      next_st.alarm[asrb_pkg::ALARM_GRAV] = next_st.alarm[asrb_pkg::ALARM_GRAV] | gravity_fail_event;
      next_st.alarm[asrb_pkg::ALARM_CONT] = next_st.alarm[asrb_pkg::ALARM_CONT] | continuous_fail_event;
    end

    // key reset keeps the pin synchronisers and the power-up flag
    if (do_soft) begin
      next_st = RST_STATE;
      next_st.sck_m = spi_in.sck;
      next_st.sck_s = st.sck_m;
      next_st.sck_d = st.sck_s;
      next_st.csb_m = spi_in.csb;
      next_st.csb_s = st.csb_m;
      next_st.csb_d = st.csb_s;
      next_st.mosi_m = spi_in.mosi;
      next_st.mosi_s = st.mosi_m;
      next_st.ctrl[asrb_pkg::CTRL_POR] = st.ctrl[asrb_pkg::CTRL_POR];
      next_st.soft_reset = 1'b1;
    end

    // miso follows the falling-edge count; released outside frames and in frames blocked by the memory test
    next_st.miso_oe_n = ~(next_st.in_frame & ~next_st.frame_blocked);
    next_st.miso = (next_st.in_frame && next_st.fallcnt < asrb_pkg::FRAME_BITS) ?
      next_st.resp[4'hf - next_st.fallcnt[3:0]] : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= RST_STATE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign spi_miso = st.miso;
  assign spi_miso_oe_n = st.miso_oe_n;
  assign power_up_flag = st.ctrl[asrb_pkg::CTRL_POR];
  assign power_down_request = st.ctrl[asrb_pkg::CTRL_PDOWN];
  assign sleep_mode = st.ctrl[asrb_pkg::CTRL_SLEEP];
  assign selfcheck_trigger = st.ctrl[asrb_pkg::CTRL_SELF];
  assign memory_check_go = st.ctrl[asrb_pkg::CTRL_MEM];
  assign selfcheck_option = st.ctrl[asrb_pkg::CTRL_OPT];
  assign soft_reset = st.soft_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_temp_pair: assert property (cap && !cap_rw && cap_addr == asrb_pkg::ADDR_TEMP_HIGH
    |=> st.temp_lat == $past(temp_word[7:0])) else $error("temperature low byte not latched");
  a_temp_low_read: assert property (cap && !cap_rw && cap_addr == asrb_pkg::ADDR_TEMP_LOW
    |=> st.resp[7:0] == $past(st.temp_lat)) else $error("temperature low read not from latch");
  a_temp_layout: assert property (MULTI_AXIS ? (temp_word[0] == 1'b0 && temp_word[15:14] == 2'b00)
    : (temp_word[15] == temp_raw[13])) else $error("temperature layout wrong");
  a_alarm_ack: assert property (cap && !cap_rw && cap_addr == asrb_pkg::ADDR_ALARM
    && !over_range_event && !gravity_fail_event && !continuous_fail_event |=> st.alarm == 8'h00)
    else $error("alarm read did not clear flags");
  a_alarm_hold: assert property (clk_en && st.alarm[asrb_pkg::ALARM_OVER]
    && !(cap && !cap_rw && cap_addr == asrb_pkg::ADDR_ALARM) |=> st.alarm[asrb_pkg::ALARM_OVER] || st.soft_reset)
    else $error("saturation flag lost without acknowledge");
  a_sleep_lock: assert property ($rose(st.ctrl[asrb_pkg::CTRL_SLEEP])
    |-> !st.ctrl[asrb_pkg::CTRL_PDOWN] && !$past(st.ctrl[asrb_pkg::CTRL_PDOWN]))
    else $error("sleep set under power-down");
  a_por_noset: assert property (!$rose(st.ctrl[asrb_pkg::CTRL_POR])) else $error("power-up flag set by link");
  a_write_edge: assert property ($changed(st.ctrl[asrb_pkg::CTRL_PDOWN]) |-> $past(csb_up && clk_en))
    else $error("control written outside chip select rise");
  a_mem_block: assert property ($rose(st.ctrl[asrb_pkg::CTRL_MEM]) |=> st.ctrl[asrb_pkg::CTRL_MEM] [*8])
    else $error("memory test ended too early");
  a_key_order: assert property ($rose(st.soft_reset) |-> $past(st.key_stage) == asrb_pkg::KEY_GOT2
    && $past(st.rx[7:0]) == asrb_pkg::KEY_THIRD) else $error("reset without full key");
  a_frame_error: assert property (clk_en && csb_up && st.in_frame && !st.frame_blocked
    && st.bitcnt != asrb_pkg::FRAME_BITS |=> st.framing_fault) else $error("bad frame not flagged");
  a_reserved_zero: assert property (cap && cap_addr == 6'h3f |=> st.resp[7:0] == 8'h00)
    else $error("reserved address read not zero");
  a_frame_header: assert property (clk_en && csb_dn |=> st.resp[14] == $past(st.framing_fault)
    && st.resp[12] == $past(st_bit) && st.resp[9:8] == 2'b10) else $error("response header wrong");

endmodule

`default_nettype wire

/* File: verification/asrb_spi_master.sv */
// spi master model standing in for the microcontroller on the serial port
`timescale 1ns/1ps
`default_nettype none

module asrb_spi_master (
  output var asrb_pkg::asrb_spi_in_t spi_in,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n
);
  initial begin
    spi_in = '{sck: 1'b0, csb: 1'b1, mosi: 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // msb first, mosi set while sck low, miso taken at sck rise; sck stands low between frames
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_in.csb = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_in.mosi = tx[15 - i];
      #62.5 spi_in.sck = 1'b1;
      rx[15 - i] = (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx;
      #62.5 spi_in.sck = 1'b0;
    end
    #62.5 spi_in.csb = 1'b1;
    // released line must not keep its last value
    spi_in.mosi = ~spi_in.mosi;
    // gap well above the four clock minimum
    #100;
  endtask
endmodule

`default_nettype wire

/* File: verification/accel_sensor_register_bank_test.sv */
// self-checking bench of the sensor register bank
`timescale 1ns/1ps
`default_nettype none

module accel_sensor_register_bank_test;
  logic clk_sys, rstn, clk_en, selfcheck_done, analog_check_active, checksum_bad, soft_seen;
  logic [2:0] ev;
  logic [13:0] temp_raw;
  logic [7:0] nvm_part_code;
  logic [15:0] rx;
  logic spi_miso, spi_miso_oe_n, power_up_flag, power_down_request, sleep_mode;
  logic selfcheck_trigger, memory_check_go, selfcheck_option, soft_reset;
  asrb_pkg::asrb_spi_in_t spi_in;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  asrb_top #(.MULTI_AXIS(1'b1), .MEMCHK_TIME_NS(500), .REVISION_CODE(8'h5a)) asrb_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .spi_in(spi_in), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .temp_raw(temp_raw), .analog_check_active(analog_check_active),
    .checksum_bad(checksum_bad), .over_range_event(ev[2]), .gravity_fail_event(ev[1]),
    .continuous_fail_event(ev[0]), .selfcheck_done(selfcheck_done), .nvm_part_code(nvm_part_code),
    .power_up_flag(power_up_flag), .power_down_request(power_down_request), .sleep_mode(sleep_mode),
    .selfcheck_trigger(selfcheck_trigger), .memory_check_go(memory_check_go),
    .selfcheck_option(selfcheck_option), .soft_reset(soft_reset)
  );

  asrb_spi_master asrb_spi_master_i (.spi_in(spi_in), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (soft_reset === 1'b1) soft_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      $display("[ERR] %0t run did not end in time", $time);
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
    n_tests++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got & mask, exp & mask);
    end
  endtask

  // data byte with odd parity; for writes the old contents come back
  task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] wd, input logic [7:0] exp);
    asrb_spi_master_i.xfer({a, w, ~^{a, w}, wd}, 16, rx);
    check(rx, {7'h01, ~^exp, exp}, 16'h01ff);
  endtask

  // header: frame error, power-up, self-test, saturation, then fixed 0 and 1
  task automatic hdr(input logic [3:0] f);
    check(rx, {1'b0, f, 2'b01, 9'h000}, 16'hfe00);
  endtask

  task automatic wait_mem();
    for (int i = 0; i < 2000 && memory_check_go !== 1'b0; i++) @(negedge clk_sys);
    check({15'h0000, memory_check_go}, 16'h0000, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    selfcheck_done = 1'b0;
    analog_check_active = 1'b0;
    checksum_bad = 1'b0;
    soft_seen = 1'b0;
    ev = 3'b000;
    temp_raw = 14'h0000;
    nvm_part_code = 8'h12;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    wait_mem();
    acc(asrb_pkg::ADDR_REVISION, 1'b0, 8'h00, 8'h5a);
    hdr(4'b0100);
    acc(asrb_pkg::ADDR_CONTROL, 1'b0, 8'h00, 8'h40);
    acc(6'h05, 1'b0, 8'h00, 8'h00);
    acc(6'h3f, 1'b0, 8'h00, 8'h00);
    acc(asrb_pkg::ADDR_PART, 1'b0, 8'h00, 8'h92);
    acc(asrb_pkg::ADDR_PART, 1'b1, 8'h33, 8'h92);
    acc(asrb_pkg::ADDR_PART, 1'b0, 8'h00, 8'h33);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h00, 8'h40);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h70, 8'h00);
    acc(asrb_pkg::ADDR_CONTROL, 1'b0, 8'h00, 8'h20);
    hdr(4'b0000);
    check({13'h0000, power_up_flag, power_down_request, sleep_mode}, 16'h0002, 16'h0007);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h2e, 8'h20);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h10, 8'h20);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h10, 8'h00);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h1e, 8'h10);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h00, 8'h10);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h0a, 8'h00);
    check({14'h0000, selfcheck_trigger, selfcheck_option}, 16'h0003, 16'h0003);
    @(negedge clk_sys) selfcheck_done = 1'b1;
    @(negedge clk_sys) selfcheck_done = 1'b0;
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h00, 8'h08);
    // bad parity write, then a short write: neither may land
    for (int k = 0; k < 2; k++) begin
      asrb_spi_master_i.xfer({asrb_pkg::ADDR_PART, 1'b1, k[0] ^ 1'b1, 8'h55}, 16 - k, rx);
      acc(asrb_pkg::ADDR_STATUS, 1'b0, 8'h00, 8'h01);
      hdr(4'b1000);
      acc(asrb_pkg::ADDR_PART, 1'b0, 8'h00, 8'h33);
      hdr(4'b0000);
    end
    @(negedge clk_sys) analog_check_active = 1'b1;
    acc(asrb_pkg::ADDR_STATUS, 1'b0, 8'h00, 8'h04);
    @(negedge clk_sys) analog_check_active = 1'b0;
    // multi-axis: 13 unsigned bits sit in 13:1, so the top sample bit is dropped
    @(negedge clk_sys) temp_raw = 14'h2abc;
    acc(asrb_pkg::ADDR_TEMP_HIGH, 1'b0, 8'h00, 8'h15);
    @(negedge clk_sys) temp_raw = 14'h1234;
    acc(asrb_pkg::ADDR_TEMP_LOW, 1'b0, 8'h00, 8'h78);
    // an event while frozen must leave no trace
    @(negedge clk_sys) clk_en = 1'b0;
    ev = 3'b100;
    repeat (2) @(negedge clk_sys);
    ev = 3'b000;
    clk_en = 1'b1;
    acc(asrb_pkg::ADDR_ALARM, 1'b0, 8'h00, 8'h00);
    // each alarm pulses briefly and must outlive its cause until read
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_sys) ev = 3'b100 >> k;
      repeat (2) @(negedge clk_sys);
      ev = 3'b000;
      repeat (3) @(negedge clk_sys);
      acc(asrb_pkg::ADDR_ALARM, 1'b0, 8'h00, {3'b100 >> k, 5'h00});
      hdr(k == 0 ? 4'b0001 : 4'b0010);
      acc(asrb_pkg::ADDR_ALARM, 1'b0, 8'h00, 8'h00);
      hdr(4'b0000);
    end
    @(negedge clk_sys) checksum_bad = 1'b1;
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h00, 8'h00);
    acc(asrb_pkg::ADDR_CONTROL, 1'b1, 8'h04, 8'h00);
    check({15'h0000, memory_check_go}, 16'h0001, 16'h0001);
    wait_mem();
    @(negedge clk_sys) checksum_bad = 1'b0;
    acc(asrb_pkg::ADDR_STATUS, 1'b0, 8'h00, 8'h02);
    hdr(4'b0010);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h0c, 8'h00);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h05, 8'h0c);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h03, 8'h05);
    check({15'h0000, soft_seen}, 16'h0000, 16'h0001);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h0c, 8'h03);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h05, 8'h0c);
    acc(asrb_pkg::ADDR_RESET_KEY, 1'b1, 8'h0f, 8'h05);
    check({15'h0000, soft_seen}, 16'h0001, 16'h0001);
    wait_mem();
    acc(asrb_pkg::ADDR_PART, 1'b0, 8'h00, 8'h92);
    acc(asrb_pkg::ADDR_STATUS, 1'b0, 8'h00, 8'h00);
    acc(asrb_pkg::ADDR_CONTROL, 1'b0, 8'h00, 8'h00);
    final_report();
  end
endmodule

`default_nettype wire
